/* hw/rpr_cfg.svh */
// Constants for the read prefetch recovery store
`ifndef RPR_CFG_SVH
`define RPR_CFG_SVH
`define RPR_DEPTH        4
`define RPR_RETAIN_BASE  3'h2
`define RPR_REGION_RECOV 2'h2
`define RPR_PTR_RESET    2'h0
`define RPR_CNT_RESET    3'h0
`endif

/* hw/rpr_pkg.sv */
// Types shared by the read prefetch recovery store
package rpr_pkg;
  typedef logic [31:0] rpr_word_t;
  typedef logic [2:0]  rpr_region_t;
  typedef logic [1:0]  rpr_enable_t;
endpackage

/* hw/rpr_recovery.sv */
// Read prefetch recovery store between backend read data and the bus data path
//
// Function
// - sync off: fetch two words beyond bus take.
// - stop backend strobes before storage overflows.
// - oldest retained word goes out first.
// - untransferred words stay held at burst end.
// - sync on: three words retained between bursts.
// - retain only when region setting equals two.
// - retained words serve same region only.
//
// Operation
// The store sits between the backend read port and the bus data path.
// A burst is the span in which i_rd_cyc is high. While it runs, the
// block asks the backend for one word per strobe cycle and keeps the
// count of words stored plus words still in flight. A word that leaves
// on the bus in the same cycle already counts as gone, so the store
// runs two words ahead of the bus, or three in sync mode.
// When the burst ends, words in flight still land in the store, and
// the next burst from the same region starts with the oldest of them.
// A burst from another region, or the end of a burst while the region
// setting is not two, empties the store instead.
// Limitation: the backend must answer each strobe with exactly one
// word, in order; a missing or extra word skews the in-flight count.
// Trade-off: the run-ahead bound counts words in flight as well as
// stored ones, so a slow backend lowers throughput but never overflows.
// Stored data has no reset; the count alone says which entries hold words.
`timescale 1ns/1ps
`default_nettype none
`include "rpr_cfg.svh"
module rpr_recovery #(
  parameter int DEPTH = `RPR_DEPTH
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire rpr_pkg::rpr_enable_t i_region_enable_setting,
  input  wire logic                 i_rd_sync,
  input  wire logic                 i_rd_cyc,
  input  wire rpr_pkg::rpr_region_t i_bar_select,
  input  wire logic                 i_be_valid,
  input  wire rpr_pkg::rpr_word_t   i_be_data,
  input  wire logic                 i_pci_take,
  output logic                      o_be_rd_stb,
  output logic                      o_pci_valid,
  output rpr_pkg::rpr_word_t        o_pci_data
);
  import rpr_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // State
  rpr_word_t        mem_ff [DEPTH];
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW-1:0]    wr_ptr_ff;
  logic [CW-1:0]    cnt_ff;
  logic [CW-1:0]    infl_ff;
  logic             rd_cyc_ff;
  rpr_region_t      region_ff;

  logic [PW-1:0]    nxt_rd_ptr;
  logic [PW-1:0]    nxt_wr_ptr;
  logic [CW-1:0]    nxt_cnt;
  logic [CW-1:0]    nxt_infl;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic            recover_en = (i_region_enable_setting == `RPR_REGION_RECOV);
  wire logic            start_w    = i_rd_cyc & ~rd_cyc_ff;
  wire logic            end_w      = rd_cyc_ff & ~i_rd_cyc;
  wire logic            mismatch_w = (i_bar_select != region_ff);
  wire logic            flush_w    = (end_w & ~recover_en) | (start_w & mismatch_w);
  // one extra word in sync mode
  wire logic [CW-1:0]   limit_w    = `RPR_RETAIN_BASE + {2'h0, i_rd_sync};
  wire logic [CW-1:0]   occ_w      = cnt_ff + infl_ff;
  // Late arrivals after a disabled burst are dropped while idle; once the next burst starts they are stored
  wire logic            keep_w     = i_rd_cyc | recover_en;
  wire logic            wr_w       = i_be_valid & keep_w & ~flush_w;
  wire logic            take_w     = i_pci_take & o_pci_valid;
  // Word leaving this cycle frees its place at once, so fetch stays a full limit ahead
  wire logic [CW-1:0]   eff_w      = occ_w - CW'(take_w);

  assign o_be_rd_stb = i_rd_cyc & ~flush_w & (eff_w < limit_w) & (eff_w < CW'(DEPTH));
  assign o_pci_valid = i_rd_cyc & ~flush_w & (cnt_ff != `RPR_CNT_RESET);
  assign o_pci_data  = mem_ff[rd_ptr_ff];

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer and count update
  always_comb begin
    nxt_rd_ptr = rd_ptr_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_cnt    = cnt_ff;
    nxt_infl   = infl_ff + CW'(o_be_rd_stb) - CW'(i_be_valid);
    if (flush_w) begin
      nxt_rd_ptr = `RPR_PTR_RESET;
      nxt_wr_ptr = `RPR_PTR_RESET;
      nxt_cnt    = `RPR_CNT_RESET;
    end else begin
      if (take_w) begin
        nxt_rd_ptr = (rd_ptr_ff == PW'(DEPTH - 1)) ? `RPR_PTR_RESET : rd_ptr_ff + 1'b1;
      end
      if (wr_w) begin
        nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? `RPR_PTR_RESET : wr_ptr_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + CW'(wr_w) - CW'(take_w);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_ptr_ff <= `RPR_PTR_RESET;
      wr_ptr_ff <= `RPR_PTR_RESET;
      cnt_ff    <= `RPR_CNT_RESET;
      infl_ff   <= `RPR_CNT_RESET;
      rd_cyc_ff <= 1'b0;
      region_ff <= 3'h0;
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
      wr_ptr_ff <= nxt_wr_ptr;
      cnt_ff    <= nxt_cnt;
      infl_ff   <= nxt_infl;
      rd_cyc_ff <= i_rd_cyc;
      if (start_w) begin
        region_ff <= i_bar_select; // Region that owns any prefetch from here on
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage entries; data needs no reset since count guards it
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge i_clk) begin
      if (wr_w && (wr_ptr_ff == PW'(g))) begin
        mem_ff[g] <= i_be_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_occ_bound: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) occ_w <= limit_w)
    else $error("Prefetch occupancy above limit");
  chk_stb_at_limit: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd_cyc && !flush_w && !i_rd_sync && occ_w < 3'h2) |-> o_be_rd_stb)
    else $error("Strobe missing below two words ahead");
  chk_sync_depth: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd_sync && o_be_rd_stb) |=> (occ_w <= 3'h3))
    else $error("Sync mode fetched beyond three words");
  chk_head_stable: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_pci_valid && !i_pci_take && i_rd_cyc) ##1 (i_rd_cyc && !flush_w)
      |-> $stable(o_pci_data))
    else $error("Head word changed before it was taken");
  chk_hold_at_end: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (end_w && recover_en) |=> (cnt_ff >= $past(cnt_ff)))
    else $error("Retained words lost at burst end");
  chk_flush_off: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (end_w && !recover_en) |=> (cnt_ff == 3'h0) ##1 (cnt_ff == 3'h0 || i_rd_cyc))
    else $error("Words kept while recovery disabled");
  chk_region_flush: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (start_w && mismatch_w) |-> !o_pci_valid ##1 (cnt_ff <= 3'h1))
    else $error("Words served to a different region");
  chk_reset_empty: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> (cnt_ff == 3'h0 && infl_ff == 3'h0 && !o_pci_valid))
    else $error("Store not empty after reset");

  chk_stb_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) !i_rd_cyc |-> !o_be_rd_stb)
    else $error("Backend strobe outside a read cycle");
  chk_valid_idle: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) !i_rd_cyc |-> !o_pci_valid)
    else $error("Bus data offered outside a read cycle");
  chk_cnt_depth: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) cnt_ff <= CW'(DEPTH))
    else $error("Store count above depth");
  chk_start_head: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (start_w && !mismatch_w && cnt_ff != 3'h0) |-> o_pci_valid)
    else $error("Retained words not offered to same region");
  chk_flush_empty: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) flush_w |=> (cnt_ff == 3'h0))
    else $error("Store not empty after flush");

  // Cover points for the main scenarios

  cov_retained_start: cover property (
    @(posedge i_clk) disable iff (!i_rst_b) start_w && !mismatch_w && cnt_ff != 3'h0);
  cov_sync_three: cover property (
    @(posedge i_clk) disable iff (!i_rst_b) end_w && recover_en && i_rd_sync && occ_w == 3'h3);
  cov_region_change: cover property (
    @(posedge i_clk) disable iff (!i_rst_b) start_w && mismatch_w && cnt_ff != 3'h0);
  cov_sync_off_two: cover property (
    @(posedge i_clk) disable iff (!i_rst_b) end_w && recover_en && !i_rd_sync && occ_w == 3'h2);
  cov_disabled_end: cover property (
    @(posedge i_clk) disable iff (!i_rst_b) end_w && !recover_en && occ_w != 3'h0);
endmodule
`default_nettype wire

/* tb/rpr_backend_model.sv */
// Backend read port model: one word per strobe, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module rpr_backend_model (
  input  wire logic          i_clk,
  input  wire logic          i_stb,
  input  wire logic          i_slow,
  output logic               o_valid,
  output rpr_pkg::rpr_word_t o_data
);
  import rpr_pkg::*;
  logic [1:0] pipe_ff = 2'h0;
  rpr_word_t  cnt_ff  = 32'h0;
  // Slow only changes while idle, or words would be lost or doubled
  assign o_valid = i_slow ? pipe_ff[1] : pipe_ff[0];
  // Idle bus shows the inverse so a stale word never passes
  assign o_data = o_valid ? cnt_ff : ~cnt_ff;
  // Words are numbered in fetch order
  always_ff @(posedge i_clk) begin
    pipe_ff <= {pipe_ff[0], i_stb};
    cnt_ff  <= cnt_ff + {31'h0, o_valid};
  end
endmodule
`default_nettype wire

/* tb/pci_read_prefetch_recovery_bench.sv */
// Bench for the read prefetch recovery store
`timescale 1ns/1ps
`default_nettype none
module pci_read_prefetch_recovery_bench;
  import rpr_pkg::*;
  logic        i_clk = 1'b0, i_rst_b = 1'b0, i_rd_sync = 1'b0, i_rd_cyc = 1'b0;
  logic        i_pci_take = 1'b0, slow = 1'b0, i_be_valid, o_be_rd_stb, o_pci_valid;
  rpr_enable_t i_region_enable_setting = 2'h2;
  rpr_region_t i_bar_select = 3'h0;
  rpr_word_t   i_be_data, o_pci_data;
  int          bad_count = 0, n_tests = 0;
  rpr_recovery dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_rd_sync(i_rd_sync),
    .i_region_enable_setting(i_region_enable_setting), .i_rd_cyc(i_rd_cyc),
    .i_bar_select(i_bar_select), .i_be_valid(i_be_valid), .i_be_data(i_be_data),
    .i_pci_take(i_pci_take), .o_be_rd_stb(o_be_rd_stb), .o_pci_valid(o_pci_valid),
    .o_pci_data(o_pci_data));
  rpr_backend_model be (.i_clk(i_clk), .i_stb(o_be_rd_stb), .i_slow(slow),
    .o_valid(i_be_valid), .o_data(i_be_data));
  initial forever #2 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input rpr_word_t got, input rpr_word_t exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One burst taking four words; numbering exposes any extra fetch
  task automatic burst(input rpr_enable_t set, input logic sync, input rpr_region_t rgn,
                       input logic ret, input rpr_word_t first, input int exp_stb);
    int k;
    int s;
    k = 0;
    s = 0;
    @(posedge i_clk);
    i_region_enable_setting <= set;
    i_rd_sync <= sync;
    i_bar_select <= rgn;
    i_rd_cyc <= 1'b1;
    i_pci_take <= 1'b1;
    @(negedge i_clk);
    check({31'h0, o_pci_valid}, {31'h0, ret});
    for (int n = 0; n < 60 && k < 4; n++) begin
      if (n > 0) @(negedge i_clk);
      if (o_be_rd_stb === 1'b1) s++;
      if (o_pci_valid === 1'b1) begin
        check(o_pci_data, first + 32'(k));
        k++;
      end
    end
    check(32'(k), 32'h4);
    check(32'(s), 32'(exp_stb));
    @(posedge i_clk);
    i_rd_cyc <= 1'b0;
    i_pci_take <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic keep_sync_off;
    burst(2'h2, 1'b0, 3'h0, 1'b0, 32'h0, 6);
    burst(2'h2, 1'b0, 3'h0, 1'b1, 32'h4, 4);
  endtask
  task automatic other_region_then_no_keep;
    burst(2'h2, 1'b0, 3'h1, 1'b0, 32'hA, 6);
    burst(2'h0, 1'b0, 3'h2, 1'b0, 32'h10, 6);
    burst(2'h2, 1'b1, 3'h2, 1'b0, 32'h16, 6);
  endtask
  task automatic keep_sync_on_slow;
    slow <= 1'b1;
    burst(2'h2, 1'b1, 3'h2, 1'b1, 32'h1A, 5);
  endtask
  task automatic reset_drops_store;
    i_rst_b <= 1'b0;
    slow <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    burst(2'h2, 1'b0, 3'h0, 1'b0, 32'h21, 6);
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    keep_sync_off();
    other_region_then_no_keep();
    keep_sync_on_slow();
    reset_drops_store();
    wrap_up();
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
